// ===== src/dts_status.sv
// Purpose: Debug trace status register with run control, reached over APB.
// Assumes: Comparator and trace-write inputs are synchronous one-cycle pulses.
// Notes:   Zero-wait APB slave; unmapped addresses read zero and raise pslverr.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "dts_params.svh"
module dts_status
    import dts_pkg::*;
#(
    parameter int DEPTH = `DTS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Trace events
    input  wire logic        match_a,
    input  wire logic        match_b,
    input  wire logic        trigger,
    input  wire logic        trace_word,
    input  wire logic        trace_read,
    // Results
    output var  logic        armed_out,
    output var  logic        irq
);
    // The four-bit count field and the full test are sized for eight words.
    if (DEPTH != `DTS_FIFO_DEPTH) begin : g_bad_depth
        $error("dts_status: count field serves a depth of 8 only");
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Every access is answered in the cycle after its setup, so writes land at the setup edge.
    logic setup;
    logic wr;
    logic rd;
    assign setup = psel && !penable;
    assign wr    = setup && pwrite;
    assign rd    = setup && !pwrite;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // Status and control are eight bits wide and sit in the low byte of the word.
    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h00_0000, b};
    endfunction : byte_word

    logic wr_ctl;
    logic wr_icl;
    logic wr_msk;
    assign wr_ctl = wr && hit(paddr, `DTS_OFF_CONTROL);
    assign wr_icl = wr && hit(paddr, `DTS_OFF_IRQ_STAT);
    assign wr_msk = wr && hit(paddr, `DTS_OFF_IRQ_MASK);

    // ----------------------------------------------------------------
    // Control and run state
    // ----------------------------------------------------------------
    // Software-visible control and the run state.
    logic        en_ff;
    logic        arm_ff;
    dts_mode_t   mode_ff;
    dts_state_t  state_ff;
    logic [2:0]  mask_ff;
    logic        nxt_en;
    logic        nxt_arm;
    dts_mode_t   nxt_mode;
    dts_state_t  nxt_state;
    logic [2:0]  nxt_mask;

    // One-cycle strobes that open and close a run.
    logic        run_start;
    logic        run_end;

    // Word count from the counter below.
    logic        count_full;
    logic [3:0]  valid_count;

    always_comb begin
        nxt_en    = en_ff;
        nxt_arm   = arm_ff;
        nxt_mode  = mode_ff;
        nxt_state = state_ff;
        nxt_mask  = mask_ff;
        run_start = 1'b0;
        run_end   = 1'b0;
        if (wr_msk) begin
            nxt_mask = pwdata[2:0];
        end
        if (wr_ctl) begin
            nxt_en   = pwdata[`DTS_CTL_EN];
            nxt_arm  = pwdata[`DTS_CTL_ARM] && pwdata[`DTS_CTL_EN];
            nxt_mode = dts_mode_t'(pwdata[`DTS_CTL_MODE]);
        end
        case (state_ff)
            DTS_IDLE: begin
                if (wr_ctl && pwdata[`DTS_CTL_EN] && pwdata[`DTS_CTL_ARM]) begin
                    run_start = 1'b1;
                    nxt_state = DTS_RUN;
                end
            end
            DTS_RUN: begin
                // A software stop outranks the hardware end conditions.
                if (wr_ctl && !(pwdata[`DTS_CTL_EN] && pwdata[`DTS_CTL_ARM])) begin
                    run_end = 1'b1;
                end else if (mode_ff == DTS_MODE_BEGIN && count_full) begin
                    run_end = 1'b1;
                end else if (mode_ff == DTS_MODE_END && trigger) begin
                    run_end = 1'b1;
                end
                if (run_end) begin
                    nxt_state = DTS_IDLE;
                    nxt_arm   = 1'b0;
                end
            end
            default: begin
                nxt_state = DTS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff    <= 1'b0;
            arm_ff   <= 1'b0;
            mode_ff  <= DTS_MODE_END;
            state_ff <= DTS_IDLE;
            mask_ff  <= `DTS_RST_MASK;
        end else begin
            en_ff    <= nxt_en;
            arm_ff   <= nxt_arm;
            mode_ff  <= nxt_mode;
            state_ff <= nxt_state;
            mask_ff  <= nxt_mask;
        end
    end

    // ----------------------------------------------------------------
    // Comparator match flags
    // ----------------------------------------------------------------
    // The flags keep their value once a run ends, so software can read them later.
    logic        match_a_flag_ff;
    logic        match_b_flag_ff;
    logic        nxt_match_a_flag;
    logic        nxt_match_b_flag;

    always_comb begin
        nxt_match_a_flag = match_a_flag_ff;
        nxt_match_b_flag = match_b_flag_ff;
        if (run_start) begin
            nxt_match_a_flag = 1'b0;
            nxt_match_b_flag = 1'b0;
        end else if (state_ff == DTS_RUN) begin
            if (match_a) begin
                nxt_match_a_flag = 1'b1;
            end
            if (match_b) begin
                nxt_match_b_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a_flag_ff <= 1'b0;
            match_b_flag_ff <= 1'b0;
        end else begin
            match_a_flag_ff <= nxt_match_a_flag;
            match_b_flag_ff <= nxt_match_b_flag;
        end
    end

    // ----------------------------------------------------------------
    // Valid word count
    // ----------------------------------------------------------------
    // The read strobe has no path into the counter, so the count holds.
    logic unused_read;
    assign unused_read = trace_read;

    // The count is cleared in the cycle the run state is entered.
    dts_counter #(
        .DEPTH (DEPTH),
        .CW    (4)
    ) u_count (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (run_start),
        .count_en (state_ff == DTS_RUN),
        .word_in  (trace_word),
        .count_ff (valid_count),
        .full     (count_full)
    );

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [2:0] ev;
    logic [2:0] icl;
    logic [2:0] ist;
    logic       irq_q;
    // Run end, and matches while running, are the three interrupt events.
    assign ev  = {match_b && state_ff == DTS_RUN, match_a && state_ff == DTS_RUN, run_end};
    assign icl = wr_icl ? pwdata[2:0] : 3'h0;

    dts_sticky #(
        .W (`DTS_EV_W)
    ) u_irq (
        .pclk      (pclk),
        .presetn   (presetn),
        .event_in  (ev),
        .clear_in  (icl),
        .mask_in   (mask_ff),
        .status_ff (ist),
        .irq_ff    (irq_q)
    );
    assign irq = irq_q;

    // ----------------------------------------------------------------
    // Status image
    // ----------------------------------------------------------------
    logic [7:0]  stat;
    logic        nxt_armed;

    always_comb begin
        stat = 8'h00;
        stat[`DTS_STAT_MATCH_A] = match_a_flag_ff;
        stat[`DTS_STAT_MATCH_B] = match_b_flag_ff;
        stat[`DTS_STAT_ARMED]   = en_ff && arm_ff;
        stat[`DTS_STAT_COUNT_HI:`DTS_STAT_COUNT_LO] = valid_count;
        // The pin follows the next value so that it agrees with the status bit.
        nxt_armed = nxt_en && nxt_arm;
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Unmapped offsets read zero and report an error; the status word refuses writes.
    logic [31:0] nxt_rdata;
    logic        nxt_err;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b0;
        if (setup) begin
            if (hit(paddr, `DTS_OFF_STATUS)) begin
                nxt_rdata = byte_word(stat);
                nxt_err   = pwrite;
            end else if (hit(paddr, `DTS_OFF_CONTROL)) begin
                nxt_rdata = byte_word({en_ff, arm_ff, 5'h00, mode_ff});
            end else if (hit(paddr, `DTS_OFF_IRQ_STAT)) begin
                nxt_rdata = {29'h0, ist};
            end else if (hit(paddr, `DTS_OFF_IRQ_MASK)) begin
                nxt_rdata = {29'h0, mask_ff};
            end else begin
                nxt_err = 1'b1;
            end
            if (!rd) begin
                nxt_rdata = 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus response registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            armed_out <= 1'b0;
        end else begin
            prdata    <= nxt_rdata;
            pready    <= setup;
            pslverr   <= nxt_err;
            armed_out <= nxt_armed;
        end
    end
endmodule : dts_status
`default_nettype wire

// ===== src/dts_params.svh
// Purpose: Offsets, field positions, reset values and counts of the debug trace status block.
// Assumes: 32-bit APB with one aligned word per register.
// Notes:   Definitions only.
`ifndef DTS_PARAMS_SVH
`define DTS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DTS_OFF_STATUS   12'h000
`define DTS_OFF_CONTROL  12'h004
`define DTS_OFF_IRQ_STAT 12'h008
`define DTS_OFF_IRQ_MASK 12'h00c

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define DTS_STAT_MATCH_A  7
`define DTS_STAT_MATCH_B  6
`define DTS_STAT_ARMED    5
`define DTS_STAT_RSVD     4
`define DTS_STAT_COUNT_HI 3
`define DTS_STAT_COUNT_LO 0

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define DTS_CTL_EN       7
`define DTS_CTL_ARM      6
`define DTS_CTL_MODE     0

// ----------------------------------------------------------------
// Interrupt event positions
// ----------------------------------------------------------------
`define DTS_EV_END       0
`define DTS_EV_MATCH_A   1
`define DTS_EV_MATCH_B   2
`define DTS_EV_W         3

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define DTS_RST_CTL      8'h00
`define DTS_RST_MASK     3'h0
`define DTS_FIFO_DEPTH   8

`endif

// ===== src/dts_pkg.sv
// Purpose: Types of the debug trace status block.
// Assumes: Nothing beyond the parameter header.
// Notes:   Offsets and counts live in dts_params.svh.
package dts_pkg;

    // ----------------------------------------------------------------
    // Run state and trace mode
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        DTS_IDLE = 1'b0,
        DTS_RUN  = 1'b1
    } dts_state_t;

    typedef enum logic [0:0] {
        DTS_MODE_END   = 1'b0,
        DTS_MODE_BEGIN = 1'b1
    } dts_mode_t;

endpackage : dts_pkg

// ===== src/dts_sticky.sv
// Purpose: Sticky interrupt status with write-one-to-clear and a mask.
// Assumes: Events are one-cycle pulses on pclk.
// Notes:   A set in the clearing cycle wins.
`timescale 1ns/10ps
`default_nettype none
module dts_sticky #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Events and software access
    input  wire logic [W-1:0] event_in,
    input  wire logic [W-1:0] clear_in,
    input  wire logic [W-1:0] mask_in,
    // Results
    output var  logic [W-1:0] status_ff,
    output var  logic         irq_ff
);
    if (W < 1) begin : g_bad_width
        $error("dts_sticky: W must be at least 1");
    end

    logic [W-1:0] nxt_status;
    logic         nxt_irq;

    always_comb begin
        nxt_status = (status_ff & ~clear_in) | event_in;
        nxt_irq    = |(nxt_status & mask_in);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= '0;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff    <= nxt_irq;
        end
    end
endmodule : dts_sticky
`default_nettype wire

// ===== src/dts_counter.sv
// Purpose: Counts trace words written during a run, saturating at the depth.
// Assumes: Reads of the trace buffer never reach this counter.
// Notes:   Cleared by the run start pulse.
`timescale 1ns/10ps
`default_nettype none
module dts_counter #(
    parameter int DEPTH = 8,
    parameter int CW    = 4
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Control
    input  wire logic          clear,
    input  wire logic          count_en,
    input  wire logic          word_in,
    // Result
    output var  logic [CW-1:0] count_ff,
    output var  logic          full
);
    if (DEPTH < 1 || DEPTH >= (1 << CW)) begin : g_bad_depth
        $error("dts_counter: DEPTH does not fit in CW bits");
    end

    localparam logic [CW-1:0] MAXC = CW'(DEPTH);

    logic [CW-1:0] nxt_count;

    always_comb begin
        nxt_count = count_ff;
        if (clear) begin
            nxt_count = '0;
        end else if (count_en && word_in && count_ff != MAXC) begin
            nxt_count = count_ff + CW'(1);
        end
    end

    assign full = (count_ff == MAXC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end
endmodule : dts_counter
`default_nettype wire

// ===== tb/dts_status_sva.sv
// Purpose: Port-level checks of the debug trace status block.
// Assumes: Zero-wait APB slave; control holds enable, arm and mode.
// Notes:   Bound to the block below.
`timescale 1ns/10ps
`default_nettype none
`include "dts_params.svh"
module dts_status_sva #(
    parameter int DEPTH = 8
) (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Events and results
    input wire logic        match_a,
    input wire logic        match_b,
    input wire logic        trigger,
    input wire logic        trace_word,
    input wire logic        trace_read,
    input wire logic        armed_out,
    input wire logic        irq
);
    logic mode_ff;
    logic nxt_mode;
    logic setup;
    assign setup = psel && !penable;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_st;
        setup && !pwrite && paddr == `DTS_OFF_STATUS;
    endsequence
    sequence s_wr_ct;
        setup && pwrite && paddr == `DTS_OFF_CONTROL;
    endsequence
    sequence s_start;
        s_wr_ct ##0 (pwdata[7:6] == 2'b11 && !armed_out);
    endsequence
    // The last written mode decides whether a trigger ends the run.
    always_comb nxt_mode = (setup && pwrite && paddr == `DTS_OFF_CONTROL) ? pwdata[`DTS_CTL_MODE] : mode_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
        end
    end
    chk_rsvd_zero: assert property (s_rd_st |=> prdata[`DTS_STAT_RSVD] == 1'b0)
        else $error("reserved bit set");
    chk_cnt_range: assert property (s_rd_st |=> prdata[3:0] <= 4'(DEPTH))
        else $error("count above depth");
    chk_ro_status: assert property (setup && pwrite && paddr == `DTS_OFF_STATUS |=> pready && pslverr)
        else $error("status write accepted");
    chk_arm_sets: assert property (s_wr_ct ##0 pwdata[7:6] == 2'b11 |-> ##[1:2] armed_out)
        else $error("arm write did not arm");
    chk_arm_stops: assert property (s_wr_ct ##0 pwdata[7:6] != 2'b11 |-> ##[1:2] !armed_out)
        else $error("run kept after stop write");
    chk_trig_ends: assert property ((armed_out && trigger && !mode_ff) |-> ##[1:2] !armed_out)
        else $error("trigger did not end run");
    chk_match_a_seen: assert property ((armed_out && match_a) ##[1:3] s_rd_st |=> prdata[`DTS_STAT_MATCH_A])
        else $error("match a not flagged");
    chk_match_b_seen: assert property ((armed_out && match_b) ##[1:3] s_rd_st |=> prdata[`DTS_STAT_MATCH_B])
        else $error("match b not flagged");
    chk_start_clr: assert property (s_start ##1 (!trace_word && !match_a && !match_b) [*2] ##1 s_rd_st
        |=> prdata[7:6] == 2'b00 && prdata[3:0] == 4'h0)
        else $error("run start left flags");
endmodule : dts_status_sva
bind dts_status dts_status_sva #(.DEPTH(DEPTH)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .match_a(match_a),
    .match_b(match_b), .trigger(trigger), .trace_word(trace_word), .trace_read(trace_read),
    .armed_out(armed_out), .irq(irq)
);
`default_nettype wire

// ===== tb/dts_host.sv
// Purpose: Debug host model: APB master and trace buffer reader.
// Assumes: The slave answers within 20 edges.
// Notes:   Keeps its own tally of words left to read.
`timescale 1ns/10ps
`default_nettype none
module dts_host (
    // Clock
    input  wire logic        pclk,
    // APB master
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Readout and hang flag
    output var  logic        trace_read,
    output var  logic        timeout
);
    int tally;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        trace_read = 1'b0;
        timeout = 1'b0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        timeout <= (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic drain(input int n_words);
        tally = n_words;
        while (tally > 0) begin
            @(posedge pclk);
            trace_read <= 1'b1;
            @(posedge pclk);
            trace_read <= 1'b0;
            tally--;
        end
    endtask : drain
endmodule : dts_host
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench of the debug trace status block.
// Assumes: Zero-wait APB slave and one-cycle event pulses.
// Notes:   t_end and t_begin drive and judge on their own; t_irq judges interrupt events that they left behind.
`timescale 1ns/10ps
`default_nettype none
`include "dts_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    localparam logic [11:0] A_ST = `DTS_OFF_STATUS;
    localparam logic [11:0] A_CT = `DTS_OFF_CONTROL;
    localparam logic [11:0] A_IS = `DTS_OFF_IRQ_STAT;
    localparam logic [11:0] A_IM = `DTS_OFF_IRQ_MASK;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trace_read;
    logic        armed_out;
    logic        irq;
    logic        tmo;
    logic [3:0]  evt;
    logic [31:0] rdat;
    logic        rerr;
    int          error_cnt;
    int          n_checks;
    dts_status #(.DEPTH(`DTS_FIFO_DEPTH)) u_dts_status (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .match_a(evt[0]), .match_b(evt[1]), .trigger(evt[2]), .trace_word(evt[3]),
        .trace_read(trace_read), .armed_out(armed_out), .irq(irq)
    );
    dts_host u_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trace_read(trace_read), .timeout(tmo)
    );
    always #2.5 pclk = ~pclk;
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    always @(posedge tmo) begin
        error_cnt++;
        summarize();
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rdat, rerr);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        u_host.xfer(1'b0, a, 32'h0, rdat, rerr);
    endtask : rd
    task automatic ev(input int k, input int n);
        repeat (n) begin
            @(posedge pclk);
            evt <= 4'(1 << k);
            @(posedge pclk);
            evt <= 4'h0;
        end
    endtask : ev
    task automatic t_end();
        rd(12'h010);
        `CHK({rerr, rdat}, 33'h100000000)
        wr(A_CT, 32'hc0);
        rd(A_ST);
        `CHK({armed_out, rdat}, 33'h100000020)
        ev(0, 1);
        rd(A_ST);
        `CHK(rdat, 32'ha0)
        ev(3, 3);
        ev(2, 1);
        rd(A_CT);
        `CHK(rdat, 32'h80)
        ev(1, 1);
        wr(A_ST, 32'h0);
        `CHK(rerr, 1'b1)
        rd(A_ST);
        `CHK(rdat, 32'h83)
        u_host.drain(int'(rdat[3:0]));
        rd(A_ST);
        `CHK(rdat, 32'h83)
        wr(A_CT, 32'hc0);
        rd(A_ST);
        `CHK(rdat, 32'h20)
        wr(A_CT, 32'h80);
        rd(A_ST);
        `CHK(rdat, 32'h0)
        $display("end-trace test done");
    endtask : t_end
    task automatic t_begin();
        wr(A_CT, 32'hc1);
        ev(2, 1);
        ev(1, 1);
        rd(A_ST);
        `CHK(rdat, 32'h60)
        ev(3, 7);
        rd(A_ST);
        `CHK(rdat, 32'h67)
        ev(3, 2);
        rd(A_ST);
        `CHK(rdat, 32'h48)
        wr(A_CT, 32'hc0);
        wr(A_CT, 32'h40);
        rd(A_ST);
        `CHK({armed_out, rdat & 32'hffffffdf}, 33'h0)
        $display("begin-trace test done");
    endtask : t_begin
    task automatic t_irq();
        rd(A_IS);
        `CHK({irq, rdat}, 33'h7)
        wr(A_IM, 32'h4);
        rd(A_IM);
        `CHK({irq, rdat}, 33'h100000004)
        wr(A_IS, 32'h4);
        rd(A_IS);
        `CHK({irq, rdat}, 33'h3)
        wr(A_IM, 32'h7);
        wr(A_IS, 32'h7);
        rd(A_IS);
        `CHK({irq, rdat}, 33'h0)
        $display("interrupt test done");
    endtask : t_irq
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        evt = 4'h0;
        error_cnt = 0;
        n_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_end();
        t_begin();
        t_irq();
        summarize();
    end
endmodule : testbench
`default_nettype wire
